// ### core/hpp_regs.svh
// Register offsets, field positions and reset values of the host port.
// Included by the top module and its bench; holds definitions and nothing else.
`ifndef HPP_REGS_SVH
`define HPP_REGS_SVH
`define HPP_OFS_DMA_CFG 8'h00
`define HPP_OFS_PIO_CFG 8'h04
`define HPP_OFS_DEV_ADDR 8'h08
`define HPP_OFS_EP_DIR 8'h0c
`define HPP_OFS_STATUS 8'h10
`define HPP_DMA_IDX_LSB 0
`define HPP_DMA_EN_BIT 4
`define HPP_DMA_WD_BIT 5
`define HPP_PIO_MUX_BIT 0
`define HPP_ST_OVR_BIT 5
`define HPP_RST_DMA_CFG 6'h00
`define HPP_RST_PIO_MUX 1'b1
`define HPP_RST_DEV_ADDR 7'h00
`define HPP_RST_EP_DIR 16'h0000
`define HPP_EP_LAST 4'he
`define HPP_STRAP_SETTLE 2'h3
`define HPP_RESP_OKAY 2'b00
`define HPP_RESP_SLVERR 2'b10
`endif

// ### core/hpp_pkg.sv
// Types shared by the host port modules.
// Compiled before every other design file.
`default_nettype none
package hpp_pkg;
    typedef enum logic [1:0] {
        HPP_MODE16 = 2'b00,
        HPP_MODE_RSV1 = 2'b01,
        HPP_MODE8 = 2'b10,
        HPP_MODE_RSV3 = 2'b11
    } hpp_mode_e;
    typedef enum logic [1:0] {
        HPP_W_IDLE = 2'b01,
        HPP_W_RESP = 2'b10
    } hpp_wstate_e;
    typedef logic [15:0] hpp_word_t;
endpackage
`default_nettype wire

// ### core/hpp_stream_if.sv
// Word stream between the host port and its two-entry buffer.
// Needs hpp_pkg compiled first.
`default_nettype none
interface hpp_stream_if;
    logic valid;
    logic ready;
    hpp_pkg::hpp_word_t data;
    logic [3:0] ep;
    logic dir;
    modport src (output valid, output data, output ep, output dir, input ready);
    modport snk (input valid, input data, input ep, input dir, output ready);
endinterface
`default_nettype wire

// ### core/hpp_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is a level that holds for several clock periods.
`default_nettype none
module hpp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// ### core/hpp_fifo2.sv
// Two-entry buffer between the port and the endpoint side.
// Both sides follow valid/ready; a stalled drain holds the fill side off.
`default_nettype none
module hpp_fifo2 (
    input wire logic clk,
    input wire logic rst_n,
    hpp_stream_if.snk fill,
    hpp_stream_if.src drain
);
    logic [20:0] mem [2];
    logic [20:0] next_mem [2];
    logic wp, rp, next_wp, next_rp;
    logic [1:0] cnt, next_cnt;
    logic push, pop;

    assign fill.ready = (cnt != 2'h2);
    assign drain.valid = (cnt != 2'h0);
    assign {drain.dir, drain.ep, drain.data} = mem[rp];
    assign push = fill.valid & fill.ready;
    assign pop = drain.valid & drain.ready;

    always_comb begin
        next_mem = mem;
        next_wp = wp;
        next_rp = rp;
        next_cnt = cnt;
        if (push) begin
            next_mem[wp] = {fill.dir, fill.ep, fill.data};
            next_wp = ~wp;
        end
        if (pop) begin
            next_rp = ~rp;
        end
        next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem[0] <= 21'h0;
            mem[1] <= 21'h0;
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'h0;
        end else begin
            mem <= next_mem;
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    a_full_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (cnt == 2'h2 && !pop) |=> (cnt == 2'h2 && !fill.ready))
        else $error("buffer lost its full state");
endmodule
`default_nettype wire

// ### core/hpp_host_port.sv
// Parallel host port of a USB peripheral controller: strap-selected bus
// mode, PIO and DMA writes into endpoint buffers, AXI4-Lite config.
// Pins are asynchronous to CLOCK; strobes must last over three clocks.
// Behaviour
// - Memory-like slave, 8/16-bit data, one address
// - Multiplexed and separate address buses both accepted
// - DMA slave serving exactly one endpoint buffer
// - DMA configuration kept apart from PIO configuration
// - Straps pick mode: 00 16-bit, 10 8-bit
// - Mode 0: sixteen lines, DMA needs width 1
// - Mode 2: eight lines, DMA needs width 0
// - Fifteen endpoints: control 0 plus fourteen; a PIO command still selects index 15
// - Each endpoint buffer reachable by PIO or DMA
// - Endpoint 0 never reachable by DMA
// - DMA endpoint index and enable in register
// - Endpoints 1 and up follow their direction bit; endpoint 0 reads as direction 1
// - Endpoint identity is address, number, direction
// - Falling address latch captures line 0
// - Low reset input resets asynchronously
`default_nettype none
`include "hpp_regs.svh"
module hpp_host_port (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic ALE,
    input wire logic COMMAND_DATA_SELECT,
    input wire logic BUS_MODE_STRAP_HI,
    input wire logic BUS_MODE_STRAP_LO,
    input wire logic [15:0] DATA_IN,
    output logic [15:0] DATA_OUT,
    output logic DATA_OE_N,
    input wire logic DACK_N,
    output logic DREQ,
    output logic EP_VALID,
    input wire logic EP_READY,
    output logic [15:0] EP_DATA,
    output logic [3:0] EP_INDEX,
    output logic EP_DIR
);
    hpp_stream_if in_if ();
    hpp_stream_if out_if ();

    logic cs_n_s, rd_n_s, wr_n_s, ale_s, a0_s, dack_n_s;
    logic [1:0] strap_s;
    logic [15:0] din_s;

    hpp_sync #(.W(24), .INIT(24'hed0000)) u_sync (
        .clk(CLOCK),
        .rst_n(RSTN),
        .d({CS_N, RD_N, WR_N, ALE, COMMAND_DATA_SELECT, DACK_N,
            BUS_MODE_STRAP_HI, BUS_MODE_STRAP_LO, DATA_IN}),
        .q({cs_n_s, rd_n_s, wr_n_s, ale_s, a0_s, dack_n_s, strap_s, din_s})
    );

    hpp_fifo2 u_buf (
        .clk(CLOCK),
        .rst_n(RSTN),
        .fill(in_if.snk),
        .drain(out_if.src)
    );

    // Register group
    logic [5:0] dma_cfg, next_dma_cfg;
    logic mux_cfg, next_mux_cfg;
    logic [6:0] dev_addr, next_dev_addr;
    logic [15:0] ep_dir, next_ep_dir;
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    hpp_pkg::hpp_wstate_e ws, next_ws;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic st_clr;
    logic do_write;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] wsb;

    // Port group
    hpp_pkg::hpp_mode_e mode, next_mode;
    logic [1:0] settle, next_settle;
    logic wr_n_q, next_wr_n_q, ale_q, next_ale_q;
    logic cmd_sel, next_cmd_sel;
    logic [3:0] ep_sel, next_ep_sel;
    logic [15:0] dout, next_dout;
    logic overrun, next_overrun;
    logic mode_ok, dma_ok, width_ok, wr_rise, ale_fall, addr_cmd;
    logic pio_wr, dma_wr, push, drive;
    logic [3:0] dma_idx, push_ep;
    logic [15:0] wmask, uid;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    assign AWREADY = !aw_held && ws == hpp_pkg::HPP_W_IDLE;
    assign WREADY = !w_held && ws == hpp_pkg::HPP_W_IDLE;
    assign BVALID = (ws == hpp_pkg::HPP_W_RESP);
    assign BRESP = bresp;
    assign ARREADY = !rvalid;
    assign RVALID = rvalid;
    assign RDATA = rdata;
    assign RRESP = rresp;
    assign wa = aw_held ? aw_addr : AWADDR;
    assign wd = w_held ? w_data : WDATA;
    assign wsb = w_held ? w_strb : WSTRB;
    assign do_write = ws == hpp_pkg::HPP_W_IDLE && (aw_held || AWVALID)
                      && (w_held || WVALID);

    always_comb begin
        next_dma_cfg = dma_cfg;
        next_mux_cfg = mux_cfg;
        next_dev_addr = dev_addr;
        next_ep_dir = ep_dir;
        next_aw_held = aw_held || (AWVALID && AWREADY);
        next_aw_addr = (AWVALID && AWREADY) ? AWADDR : aw_addr;
        next_w_held = w_held || (WVALID && WREADY);
        next_w_data = (WVALID && WREADY) ? WDATA : w_data;
        next_w_strb = (WVALID && WREADY) ? WSTRB : w_strb;
        next_ws = ws;
        next_bresp = bresp;
        st_clr = 1'b0;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_ws = hpp_pkg::HPP_W_RESP;
            next_bresp = `HPP_RESP_OKAY;
            // DMA and PIO settings sit in separate words
            if (wa == `HPP_OFS_DMA_CFG) begin
                next_dma_cfg = 6'(merge({26'h0, dma_cfg}, wd, wsb));
            end else if (wa == `HPP_OFS_PIO_CFG) begin
                next_mux_cfg = 1'(merge({31'h0, mux_cfg}, wd, wsb) >> `HPP_PIO_MUX_BIT);
            end else if (wa == `HPP_OFS_DEV_ADDR) begin
                next_dev_addr = 7'(merge({25'h0, dev_addr}, wd, wsb));
            end else if (wa == `HPP_OFS_EP_DIR) begin
                next_ep_dir = 16'(merge({16'h0, ep_dir}, wd, wsb));
            end else if (wa == `HPP_OFS_STATUS) begin
                st_clr = wsb[0] && wd[`HPP_ST_OVR_BIT];
            end else begin
                next_bresp = `HPP_RESP_SLVERR;
            end
        end else if (ws == hpp_pkg::HPP_W_RESP && BREADY) begin
            next_ws = hpp_pkg::HPP_W_IDLE;
        end
        next_rvalid = rvalid ? !RREADY : ARVALID;
        next_rdata = rdata;
        next_rresp = rresp;
        if (ARVALID && ARREADY) begin
            next_rresp = `HPP_RESP_OKAY;
            if (ARADDR == `HPP_OFS_DMA_CFG) begin
                next_rdata = {26'h0, dma_cfg};
            end else if (ARADDR == `HPP_OFS_PIO_CFG) begin
                next_rdata = {31'h0, mux_cfg};
            end else if (ARADDR == `HPP_OFS_DEV_ADDR) begin
                next_rdata = {25'h0, dev_addr};
            end else if (ARADDR == `HPP_OFS_EP_DIR) begin
                next_rdata = {16'h0, ep_dir};
            end else if (ARADDR == `HPP_OFS_STATUS) begin
                next_rdata = {26'h0, overrun, !in_if.ready, dma_ok, mode_ok, mode};
            end else begin
                next_rdata = 32'h0;
                next_rresp = `HPP_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            dma_cfg <= `HPP_RST_DMA_CFG;
            mux_cfg <= `HPP_RST_PIO_MUX;
            dev_addr <= `HPP_RST_DEV_ADDR;
            ep_dir <= `HPP_RST_EP_DIR;
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            ws <= hpp_pkg::HPP_W_IDLE;
            bresp <= `HPP_RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `HPP_RESP_OKAY;
        end else begin
            dma_cfg <= next_dma_cfg;
            mux_cfg <= next_mux_cfg;
            dev_addr <= next_dev_addr;
            ep_dir <= next_ep_dir;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            ws <= next_ws;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // Reserved codes leave mode_ok low, so nothing moves
    assign mode_ok = settle == `HPP_STRAP_SETTLE
                     && (mode == hpp_pkg::HPP_MODE16 || mode == hpp_pkg::HPP_MODE8);
    assign dma_idx = dma_cfg[`HPP_DMA_IDX_LSB +: 4];
    assign width_ok = (mode == hpp_pkg::HPP_MODE16) ? dma_cfg[`HPP_DMA_WD_BIT]
                                                    : !dma_cfg[`HPP_DMA_WD_BIT];
    assign dma_ok = mode_ok && dma_cfg[`HPP_DMA_EN_BIT] && width_ok
                    && dma_idx != 4'h0 && dma_idx <= `HPP_EP_LAST;
    assign wmask = (mode == hpp_pkg::HPP_MODE16) ? 16'hffff : 16'h00ff;
    assign wr_rise = !wr_n_q && wr_n_s;
    assign ale_fall = ale_q && !ale_s;
    // Separate bus: address pin picks command; multiplexed: latched line 0
    assign addr_cmd = mux_cfg ? cmd_sel : a0_s;
    assign pio_wr = wr_rise && !cs_n_s && dack_n_s && mode_ok;
    assign dma_wr = wr_rise && !dack_n_s && dma_ok;
    assign push = (pio_wr && !addr_cmd) || dma_wr;
    assign push_ep = dma_wr ? dma_idx : ep_sel;
    assign drive = !cs_n_s && !rd_n_s && dack_n_s && mode_ok;
    // Endpoint 0 is both directions; PIO data to it heads for control IN
    assign uid = {dev_addr, ep_sel, ep_dir[ep_sel] | (ep_sel == 4'h0), 4'h0};

    assign in_if.valid = push;
    assign in_if.data = din_s & wmask;
    assign in_if.ep = push_ep;
    assign in_if.dir = ep_dir[push_ep] | (push_ep == 4'h0);
    assign out_if.ready = EP_READY;
    assign EP_VALID = out_if.valid;
    assign EP_DATA = out_if.data;
    assign EP_INDEX = out_if.ep;
    assign EP_DIR = out_if.dir;
    // A full buffer drops DREQ so DMA stalls instead of losing words
    assign DREQ = dma_ok && in_if.ready;
    assign DATA_OUT = dout;
    assign DATA_OE_N = !drive;

    always_comb begin
        next_settle = (settle == `HPP_STRAP_SETTLE) ? settle : settle + 2'h1;
        next_mode = (settle == `HPP_STRAP_SETTLE) ? mode : hpp_pkg::hpp_mode_e'(strap_s);
        next_wr_n_q = wr_n_s;
        next_ale_q = ale_s;
        next_cmd_sel = (ale_fall && mux_cfg) ? din_s[0] : cmd_sel;
        next_ep_sel = (pio_wr && addr_cmd) ? din_s[3:0] : ep_sel;
        next_dout = (addr_cmd ? {8'h00, 4'h0, ep_sel} : uid) & wmask;
        next_overrun = (push && !in_if.ready) || (overrun && !st_clr);
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            settle <= 2'h0;
            mode <= hpp_pkg::HPP_MODE_RSV3;
            wr_n_q <= 1'b1;
            ale_q <= 1'b0;
            cmd_sel <= 1'b0;
            ep_sel <= 4'h0;
            dout <= 16'h0000;
            overrun <= 1'b0;
        end else begin
            settle <= next_settle;
            mode <= next_mode;
            wr_n_q <= next_wr_n_q;
            ale_q <= next_ale_q;
            cmd_sel <= next_cmd_sel;
            ep_sel <= next_ep_sel;
            dout <= next_dout;
            overrun <= next_overrun;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    sequence s_resp_waiting;
        BVALID && !BREADY;
    endsequence

    a_dma_no_ep0: assert property (dma_wr |-> (push_ep != 4'h0 && push_ep <= 4'he))
        else $error("DMA reached a forbidden endpoint");
    a_reserved_silent: assert property (mode[0] |-> !push && DATA_OE_N && !DREQ)
        else $error("transfer under reserved mode");
    a_width_refuse: assert property (DREQ |-> (mode == hpp_pkg::HPP_MODE16)
                                     == dma_cfg[`HPP_DMA_WD_BIT])
        else $error("DMA offered with mismatched width");
    a_ale_capture: assert property ((ale_fall && mux_cfg) |=> cmd_sel == $past(din_s[0]))
        else $error("address latch missed line 0");
    a_dir_follow: assert property (push && push_ep != 4'h0
                                   |-> in_if.dir == ep_dir[push_ep])
        else $error("direction not taken from its bit");
    a_dma_cfg_apart: assert property ((do_write && wa != `HPP_OFS_DMA_CFG)
                                      |=> $stable(dma_cfg))
        else $error("DMA config changed by another write");
    a_uid_read: assert property ((drive && !addr_cmd && $stable(ep_sel))
                                 |=> dout[15:9] == (dev_addr & wmask[15:9]))
        else $error("identity word wrong");
    a_eight_bit_mask: assert property ((push && mode == hpp_pkg::HPP_MODE8)
                                       |-> in_if.data[15:8] == 8'h00)
        else $error("upper lines used in 8-bit mode");
    a_write_resp: assert property (s_resp_waiting |=> (BVALID && $stable(BRESP)))
        else $error("write response not held");
endmodule
`default_nettype wire

// ### test/hpp_mcu_model.sv
// Microcontroller model on the pin side of the host port.
// Assumes the bench calls xfer right after a rising CLOCK edge.
`default_nettype none
module hpp_mcu_model (
    input wire logic CLOCK,
    input wire logic MUX,
    input wire logic [15:0] DATA_OUT,
    input wire logic DATA_OE_N,
    output logic CS_N,
    output logic RD_N,
    output logic WR_N,
    output logic ALE,
    output logic COMMAND_DATA_SELECT,
    output logic DACK_N,
    output logic [15:0] DATA_IN
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv = 1'b0;
    logic [15:0] dq = 16'h0000;
    initial begin
        {CS_N, RD_N, WR_N, DACK_N} = 4'hf;
        ALE = 1'b0;
        COMMAND_DATA_SELECT = 1'b0;
    end
    // Released lines show the inverse of the last value, never a stale copy
    assign DATA_IN = !DATA_OE_N ? DATA_OUT : drv ? dq : ~dq;
    // Strobe phases held five clocks, ALE phases four: the port syncs its pins through two flops
    task automatic xfer(input logic rd, input logic dma, input logic cmd,
                        input logic [15:0] d, output logic [15:0] q);
        if (MUX && !dma) begin
            dq <= {dq[15:1], cmd};
            drv <= 1'b1;
            ALE <= 1'b1;
            repeat (4) @(posedge CLOCK);
            ALE <= 1'b0;
            repeat (4) @(posedge CLOCK);
        end
        COMMAND_DATA_SELECT <= MUX ? 1'b0 : cmd;
        dq <= d;
        drv <= !rd;
        CS_N <= dma;
        DACK_N <= !dma;
        @(posedge CLOCK);
        if (rd) RD_N <= 1'b0;
        else WR_N <= 1'b0;
        repeat (5) @(posedge CLOCK);
        q = DATA_IN;
        RD_N <= 1'b1;
        WR_N <= 1'b1;
        repeat (5) @(posedge CLOCK);
        CS_N <= 1'b1;
        DACK_N <= 1'b1;
        drv <= 1'b0;
        repeat (3) @(posedge CLOCK);
    endtask
endmodule
`default_nettype wire

// ### test/hpp_host_port_tb_top.sv
// Bench for the host port: AXI4-Lite set-up, pin and DMA writes, stream drain.
// Assumes hpp_mcu_model drives the pins; expected stream words queue in order.
`default_nettype none
`include "hpp_regs.svh"
module hpp_host_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK = 1'b0;
    logic RSTN = 1'b0;
    logic [7:0] AWADDR = '0, ARADDR = '0;
    logic [31:0] WDATA = '0;
    logic [3:0] WSTRB = 4'hf;
    logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic BUS_MODE_STRAP_HI = 0, BUS_MODE_STRAP_LO = 0, EP_READY = 0;
    wire logic AWREADY, WREADY, BVALID, ARREADY, RVALID, DATA_OE_N, DREQ, EP_VALID, EP_DIR;
    wire logic CS_N, RD_N, WR_N, ALE, COMMAND_DATA_SELECT, DACK_N;
    wire logic [1:0] BRESP, RRESP;
    wire logic [31:0] RDATA;
    wire logic [15:0] DATA_IN, DATA_OUT, EP_DATA;
    wire logic [3:0] EP_INDEX;
    int n_mismatch = 0, compares = 0, cyc = 0, seed = 89027;
    logic [20:0] expq[$];
    logic stall = 1'b0, mux = 1'b1;
    logic [15:0] q, w;
    logic [31:0] rd;
    logic [31:0] bad [4] = '{32'h30, 32'h3f, 32'h25, 32'h15};
    logic [1:0] modes [4] = '{2'b00, 2'b01, 2'b11, 2'b10};

    always #25 CLOCK = ~CLOCK;

    hpp_host_port hpp_host_port_inst (.CLOCK, .RSTN, .AWADDR, .AWVALID, .AWREADY, .WDATA,
        .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
        .RDATA, .RRESP, .RVALID, .RREADY, .CS_N, .RD_N, .WR_N, .ALE, .COMMAND_DATA_SELECT,
        .BUS_MODE_STRAP_HI, .BUS_MODE_STRAP_LO, .DATA_IN, .DATA_OUT, .DATA_OE_N, .DACK_N,
        .DREQ, .EP_VALID, .EP_READY, .EP_DATA, .EP_INDEX, .EP_DIR);
    hpp_mcu_model hpp_mcu_model_inst (.CLOCK, .MUX(mux), .DATA_OUT, .DATA_OE_N, .CS_N,
        .RD_N, .WR_N, .ALE, .COMMAND_DATA_SELECT, .DACK_N, .DATA_IN);

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Random drain stalls; a word popped with nothing noted is a stray push
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
        EP_READY <= !stall && ($random(seed) & 1);
        if (EP_VALID && EP_READY) begin
            if (expq.size() == 0) chk("stray stream word", 0, 1);
            else chk("stream word", expq.pop_front(), {EP_INDEX, EP_DIR, EP_DATA});
        end
    end

    task automatic reset(input logic [1:0] m);
        @(negedge CLOCK);
        RSTN = 1'b0;
        #1 chk("dreq in reset", 0, DREQ);
        {BUS_MODE_STRAP_HI, BUS_MODE_STRAP_LO} = m;
        mux <= 1'b1;
        repeat (5) @(posedge CLOCK);
        RSTN <= 1'b1;
        repeat (4) @(posedge CLOCK);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        // Late ready now and then, so the response must stand while it waits
        BREADY <= 1'($random(seed));
        do begin
            @(posedge CLOCK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
            if (BVALID) BREADY <= 1'b1;
            n++;
        end while (!(BVALID && BREADY) && n < 40);
        chk("write answer", 1, BVALID && BREADY);
        chk("write resp", r, BRESP);
        BREADY <= 1'b0;
        @(posedge CLOCK);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                          input logic [1:0] er);
        int n = 0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge CLOCK);
            if (ARREADY) ARVALID <= 1'b0;
            n++;
        end while (!RVALID && n < 40);
        chk("read answer", 1, RVALID);
        rd = RDATA;
        chk("read data", e, RDATA & m);
        chk("read resp", er, RRESP);
        RREADY <= 1'b0;
        @(posedge CLOCK);
    endtask

    task automatic pin(input logic r, input logic dma, input logic cmd, input logic [15:0] d);
        hpp_mcu_model_inst.xfer(r, dma, cmd, d, q);
    endtask

    initial begin
        reset(2'b00);
        axi_rd(`HPP_OFS_DMA_CFG, 32'h3f, 32'h00, `HPP_RESP_OKAY);
        axi_rd(`HPP_OFS_PIO_CFG, 32'h01, 32'h01, `HPP_RESP_OKAY);
        axi_rd(`HPP_OFS_STATUS, 32'h3f, 32'h04, `HPP_RESP_OKAY);
        axi_rd(8'h14, 32'hffffffff, 32'h0, `HPP_RESP_SLVERR);
        axi_wr(8'h14, 32'h1, `HPP_RESP_SLVERR);
        axi_wr(`HPP_OFS_DEV_ADDR, 32'h2a, `HPP_RESP_OKAY);
        axi_wr(`HPP_OFS_EP_DIR, 32'h28, `HPP_RESP_OKAY);
        // Multiplexed bus: command bit comes from the address latch
        // Only endpoints 3, 5, 7 and 9 carry words: far inside storage budget
        pin(0, 0, 1, 16'h0007);
        for (int i = 0; i < 3; i++) begin
            w = $random(seed);
            expq.push_back({4'h7, 1'b0, w});
            pin(0, 0, 0, w);
        end
        axi_wr(`HPP_OFS_DMA_CFG, 32'h35, `HPP_RESP_OKAY);
        axi_wr(`HPP_OFS_PIO_CFG, 32'h0, `HPP_RESP_OKAY);
        mux <= 1'b0;
        axi_rd(`HPP_OFS_DMA_CFG, 32'h3f, 32'h35, `HPP_RESP_OKAY);
        axi_rd(`HPP_OFS_STATUS, 32'h0c, 32'h0c, `HPP_RESP_OKAY);
        chk("dreq enabled", 1, DREQ);
        expq.push_back({4'h5, 1'b1, 16'h1234});
        pin(0, 1, 0, 16'h1234);
        pin(0, 0, 1, 16'h0003);
        pin(1, 0, 1, 16'h0000);
        chk("command read", 16'h0003, q);
        pin(1, 0, 0, 16'h0000);
        chk("data read", {7'h2a, 4'h3, 1'b1, 4'h0}, q);
        expq.push_back({4'h3, 1'b1, 16'hc3a5});
        pin(0, 0, 0, 16'hc3a5);
        foreach (bad[i]) begin
            axi_wr(`HPP_OFS_DMA_CFG, bad[i], `HPP_RESP_OKAY);
            axi_rd(`HPP_OFS_STATUS, 32'h08, 32'h00, `HPP_RESP_OKAY);
            chk("dreq refused", 0, DREQ);
            pin(0, 1, 0, 16'hdead);
        end
        // Stall the drain until the buffer refuses, then lose one word
        stall <= 1'b1;
        rd = '0;
        for (int i = 0; i < 6 && !rd[4]; i++) begin
            w = $random(seed);
            expq.push_back({4'h3, 1'b1, w});
            pin(0, 0, 0, w);
            axi_rd(`HPP_OFS_STATUS, 32'h0, 32'h0, `HPP_RESP_OKAY);
        end
        chk("buffer full", 1, rd[4]);
        pin(0, 0, 0, 16'h5555);
        axi_rd(`HPP_OFS_STATUS, 32'h30, 32'h30, `HPP_RESP_OKAY);
        axi_wr(`HPP_OFS_STATUS, 32'h20, `HPP_RESP_OKAY);
        stall <= 1'b0;
        repeat (30) @(posedge CLOCK);
        axi_rd(`HPP_OFS_STATUS, 32'h30, 32'h00, `HPP_RESP_OKAY);
        axi_wr(`HPP_OFS_DMA_CFG, 32'h35, `HPP_RESP_OKAY);
        foreach (modes[i]) begin
            reset(modes[i]);
            axi_rd(`HPP_OFS_STATUS, 32'h0f, {29'h0, !modes[i][0], modes[i]},
                   `HPP_RESP_OKAY);
            if (modes[i][0]) pin(0, 0, 0, 16'h1234);
        end
        pin(0, 0, 1, 16'h0009);
        expq.push_back({4'h9, 1'b0, 16'h00ef});
        pin(0, 0, 0, 16'hbeef);
        pin(1, 0, 1, 16'h0000);
        chk("narrow command read", 16'h0009, q);
        axi_wr(`HPP_OFS_DMA_CFG, 32'h19, `HPP_RESP_OKAY);
        chk("dreq narrow", 1, DREQ);
        axi_wr(`HPP_OFS_DMA_CFG, 32'h39, `HPP_RESP_OKAY);
        chk("dreq width clash", 0, DREQ);
        repeat (30) @(posedge CLOCK);
        chk("words left", 0, expq.size());
        test_done();
    end
endmodule
`default_nettype wire
